// ---- shared/instr_decode_pkg.sv ----
package instr_decode_pkg;

   // Opcode space and timing figures.
   localparam int           OPCODE_W       = 8;
   localparam int           CYC_W          = 4;
   localparam int           LEN_W          = 2;
   localparam logic [3:0]   CYC_MUL        = 4'h4;
   localparam logic [3:0]   CYC_DIV        = 4'h8;
   localparam logic [3:0]   CYC_CODE_MOVE  = 4'h3;
   localparam logic [3:0]   CYC_EXT_MOVE   = 4'h3;
   localparam logic [3:0]   CYC_CPL_A      = 4'h2;
   localparam logic [3:0]   CYC_INDIRECT   = 4'h2;
   localparam logic [3:0]   CYC_ONE        = 4'h1;
   localparam logic [3:0]   CYC_BRANCH_ADD = 4'h1;
   localparam logic [1:0]   LEN_ONE        = 2'h1;
   localparam logic [1:0]   LEN_TWO        = 2'h2;
   localparam logic [1:0]   LEN_THREE      = 2'h3;
   localparam logic [7:0]   RESET_OPCODE   = 8'h00;

   // Operation classes handed to the execute stage.
   typedef enum logic [3:0]
   {
      OP_NONE,
      OP_ARITH,
      OP_LOGIC,
      OP_ACC_UNARY,
      OP_MOVE,
      OP_CODE_MOVE,
      OP_EXT_READ,
      OP_EXT_WRITE,
      OP_STACK,
      OP_EXCHANGE,
      OP_NIBBLE_XCH,
      OP_MULDIV,
      OP_INCDEC,
      OP_BRANCH,
      OP_OTHER
   } op_class_e;

   // Decoded instruction bundle.
   typedef struct packed
   {
      op_class_e     op_class;
      logic [1:0]    length;
      logic [3:0]    cycles;
      logic          indirect;
      logic          is_cond_branch;
      logic          flash_target;
      logic          ext_addr16;
   } decode_s;

endpackage

// ---- logic/cycle_timed_instr_decoder.sv ----
`timescale 1ns/1ps
module cycle_timed_instr_decoder
(
   // Clock and reset
   input  wire logic                                        core_clk,
   input  wire logic                                        rst_n,
   // Fetch side
   input  wire logic                                        opcode_valid,
   input  wire logic [instr_decode_pkg::OPCODE_W-1:0]       opcode,
   input  wire logic                                        flash_write_en,
   input  wire logic                                        branch_taken,
   // Decode and timing out
   output logic                                             busy,
   output logic                                             instr_done,
   output instr_decode_pkg::decode_s                        decode_out
);

   logic                              rst_meta_ff;
   logic                              rst_sync_n_ff;
   instr_decode_pkg::decode_s         nxt_dec;
   instr_decode_pkg::decode_s         dec_ff;
   logic [instr_decode_pkg::CYC_W-1:0] remain_ff;
   logic                              busy_ff;
   logic                              done_ff;
   logic                              accept;
   logic [instr_decode_pkg::CYC_W-1:0] total_cycles;
   logic [2:0]                        lo3;
   logic [3:0]                        hi4;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_ff   <= 1'b0;
         rst_sync_n_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff   <= 1'b1;
         rst_sync_n_ff <= rst_meta_ff;
      end
   end

   assign lo3 = opcode[2:0];
   assign hi4 = opcode[7:4];

   // Length and cycles come from the opcode column: 8..f is a bank register,
   // 6/7 indirect, 5 direct, 4 immediate or accumulator-only forms.
   always_comb
   begin
      nxt_dec                = '0;
      nxt_dec.op_class       = instr_decode_pkg::OP_OTHER;
      nxt_dec.length         = instr_decode_pkg::LEN_ONE;
      nxt_dec.cycles         = instr_decode_pkg::CYC_ONE;
      if (opcode[3])
      begin
         nxt_dec.length = instr_decode_pkg::LEN_ONE;
         nxt_dec.cycles = instr_decode_pkg::CYC_ONE;
         unique case (hi4)
            4'h2, 4'h3, 4'h9: nxt_dec.op_class = instr_decode_pkg::OP_ARITH;
            4'h4, 4'h5, 4'h6: nxt_dec.op_class = instr_decode_pkg::OP_LOGIC;
            4'hc:             nxt_dec.op_class = instr_decode_pkg::OP_EXCHANGE;
            4'h0, 4'h1:       nxt_dec.op_class = instr_decode_pkg::OP_INCDEC;
            4'h7, 4'ha, 4'he, 4'hf, 4'h8: nxt_dec.op_class = instr_decode_pkg::OP_MOVE;
            4'hb, 4'hd:
            begin
               nxt_dec.op_class       = instr_decode_pkg::OP_BRANCH;
               nxt_dec.is_cond_branch = 1'b1;
               nxt_dec.length         = (hi4 == 4'hb) ? instr_decode_pkg::LEN_THREE : instr_decode_pkg::LEN_TWO;
               nxt_dec.cycles         = {2'h0, nxt_dec.length};
            end
         endcase
         if (hi4 == 4'h7 || hi4 == 4'ha || hi4 == 4'h8)
         begin
            nxt_dec.length = instr_decode_pkg::LEN_TWO;
            nxt_dec.cycles = {2'h0, instr_decode_pkg::LEN_TWO};
         end
      end
      else if (lo3 == 3'h6 || lo3 == 3'h7)
      begin
         nxt_dec.indirect = 1'b1;
         nxt_dec.length   = instr_decode_pkg::LEN_ONE;
         nxt_dec.cycles   = instr_decode_pkg::CYC_INDIRECT;
         unique case (hi4)
            4'h2, 4'h3, 4'h9: nxt_dec.op_class = instr_decode_pkg::OP_ARITH;
            4'h4, 4'h5, 4'h6: nxt_dec.op_class = instr_decode_pkg::OP_LOGIC;
            4'hc:             nxt_dec.op_class = instr_decode_pkg::OP_EXCHANGE;
            4'hd:             nxt_dec.op_class = instr_decode_pkg::OP_NIBBLE_XCH;
            4'h0, 4'h1:       nxt_dec.op_class = instr_decode_pkg::OP_INCDEC;
            4'hf, 4'he:       nxt_dec.op_class = instr_decode_pkg::OP_MOVE;
            4'h7, 4'ha, 4'h8:
            begin
               nxt_dec.op_class = instr_decode_pkg::OP_MOVE;
               nxt_dec.length   = instr_decode_pkg::LEN_TWO;
            end
            4'hb:
            begin
               nxt_dec.op_class       = instr_decode_pkg::OP_BRANCH;
               nxt_dec.is_cond_branch = 1'b1;
               nxt_dec.length         = instr_decode_pkg::LEN_THREE;
               nxt_dec.cycles         = 4'h4;
            end
            default:          nxt_dec.op_class = instr_decode_pkg::OP_OTHER;
         endcase
      end
      else
      begin
         unique case (opcode)
            8'h24, 8'h34, 8'h94, 8'h25, 8'h35, 8'h95:
            begin
               nxt_dec.op_class = instr_decode_pkg::OP_ARITH;
               nxt_dec.length   = instr_decode_pkg::LEN_TWO;
            end
            8'h44, 8'h54, 8'h64, 8'h45, 8'h55, 8'h65, 8'h42, 8'h52, 8'h62:
            begin
               nxt_dec.op_class = instr_decode_pkg::OP_LOGIC;
               nxt_dec.length   = instr_decode_pkg::LEN_TWO;
            end
            8'h43, 8'h53, 8'h63:
            begin
               nxt_dec.op_class = instr_decode_pkg::OP_LOGIC;
               nxt_dec.length   = instr_decode_pkg::LEN_THREE;
            end
            8'he4, 8'h03, 8'h13, 8'h23, 8'h33, 8'hc4:
               nxt_dec.op_class = instr_decode_pkg::OP_ACC_UNARY;
            8'hd4:
               nxt_dec.op_class = instr_decode_pkg::OP_ACC_UNARY;
            8'hf4:
            begin
               nxt_dec.op_class = instr_decode_pkg::OP_ACC_UNARY;
               nxt_dec.cycles   = instr_decode_pkg::CYC_CPL_A;
            end
            8'h85, 8'h75:
            begin
               nxt_dec.op_class = instr_decode_pkg::OP_MOVE;
               nxt_dec.length   = instr_decode_pkg::LEN_THREE;
            end
            8'h90:
            begin
               nxt_dec.op_class = instr_decode_pkg::OP_MOVE;
               nxt_dec.length   = instr_decode_pkg::LEN_THREE;
            end
            8'he5, 8'h74, 8'hf5:
            begin
               nxt_dec.op_class = instr_decode_pkg::OP_MOVE;
               nxt_dec.length   = instr_decode_pkg::LEN_TWO;
            end
            8'h93, 8'h83:
               nxt_dec.op_class = instr_decode_pkg::OP_CODE_MOVE;
            8'he0, 8'he2:
            begin
               nxt_dec.op_class   = instr_decode_pkg::OP_EXT_READ;
               nxt_dec.ext_addr16 = (opcode == 8'he0);
            end
            8'hf0, 8'hf2:
            begin
               nxt_dec.op_class     = instr_decode_pkg::OP_EXT_WRITE;
               nxt_dec.ext_addr16   = (opcode == 8'hf0);
               nxt_dec.flash_target = flash_write_en;
            end
            8'hc0, 8'hd0:
            begin
               nxt_dec.op_class = instr_decode_pkg::OP_STACK;
               nxt_dec.length   = instr_decode_pkg::LEN_TWO;
            end
            8'hc5:
            begin
               nxt_dec.op_class = instr_decode_pkg::OP_EXCHANGE;
               nxt_dec.length   = instr_decode_pkg::LEN_TWO;
            end
            8'h05, 8'h15:
            begin
               nxt_dec.op_class = instr_decode_pkg::OP_INCDEC;
               nxt_dec.length   = instr_decode_pkg::LEN_TWO;
            end
            8'h04, 8'h14, 8'ha3:
               nxt_dec.op_class = instr_decode_pkg::OP_INCDEC;
            8'ha4:
            begin
               nxt_dec.op_class = instr_decode_pkg::OP_MULDIV;
               nxt_dec.cycles   = instr_decode_pkg::CYC_MUL;
            end
            8'h84:
            begin
               nxt_dec.op_class = instr_decode_pkg::OP_MULDIV;
               nxt_dec.cycles   = instr_decode_pkg::CYC_DIV;
            end
            8'h40, 8'h50, 8'h60, 8'h70:
            begin
               nxt_dec.op_class       = instr_decode_pkg::OP_BRANCH;
               nxt_dec.is_cond_branch = 1'b1;
               nxt_dec.length         = instr_decode_pkg::LEN_TWO;
            end
            8'h20, 8'h30, 8'h10, 8'hb4, 8'hd5:
            begin
               nxt_dec.op_class       = instr_decode_pkg::OP_BRANCH;
               nxt_dec.is_cond_branch = 1'b1;
               nxt_dec.length         = instr_decode_pkg::LEN_THREE;
            end
            8'hb5:
            begin
               nxt_dec.op_class       = instr_decode_pkg::OP_BRANCH;
               nxt_dec.is_cond_branch = 1'b1;
               nxt_dec.length         = instr_decode_pkg::LEN_THREE;
               nxt_dec.cycles         = 4'h4;
            end
            default:
               nxt_dec.op_class = instr_decode_pkg::OP_OTHER;
         endcase
         // Plain forms cost one clock per program byte.
         if (nxt_dec.cycles == instr_decode_pkg::CYC_ONE && nxt_dec.op_class != instr_decode_pkg::OP_ACC_UNARY
             && opcode != 8'ha3)
            nxt_dec.cycles = {2'h0, nxt_dec.length};
         if (nxt_dec.op_class == instr_decode_pkg::OP_CODE_MOVE)
            nxt_dec.cycles = instr_decode_pkg::CYC_CODE_MOVE;
         if (nxt_dec.op_class == instr_decode_pkg::OP_EXT_READ || nxt_dec.op_class == instr_decode_pkg::OP_EXT_WRITE)
            nxt_dec.cycles = instr_decode_pkg::CYC_EXT_MOVE;
      end
   end

   // The branch outcome is sampled at issue, so the untaken cost is the
   // base figure and a taken branch adds one clock.
   assign accept       = opcode_valid && !busy_ff;
   assign total_cycles = nxt_dec.cycles + ((nxt_dec.is_cond_branch && branch_taken) ?
                         instr_decode_pkg::CYC_BRANCH_ADD : 4'h0);

   always_ff @(posedge core_clk or negedge rst_sync_n_ff)
   begin
      if (!rst_sync_n_ff)
         dec_ff <= '0;
      else if (accept)
         dec_ff <= nxt_dec;
   end

   // Pure clock-cycle countdown with no machine-cycle prescaler.
   always_ff @(posedge core_clk or negedge rst_sync_n_ff)
   begin
      if (!rst_sync_n_ff)
      begin
         remain_ff <= '0;
         busy_ff   <= 1'b0;
         done_ff   <= 1'b0;
      end
      else if (accept)
      begin
         remain_ff <= total_cycles - 4'h1;
         busy_ff   <= (total_cycles != 4'h1);
         done_ff   <= (total_cycles == 4'h1);
      end
      else if (busy_ff)
      begin
         remain_ff <= remain_ff - 4'h1;
         busy_ff   <= (remain_ff != 4'h1);
         done_ff   <= (remain_ff == 4'h1);
      end
      else
         done_ff <= 1'b0;
   end

   assign busy       = busy_ff;
   assign instr_done = done_ff;
   assign decode_out = dec_ff;

   mul_four_a : assert property (@(posedge core_clk) disable iff (!rst_sync_n_ff)
      (accept && opcode == 8'ha4) |-> ##4 instr_done)
      else $error("Multiply did not finish in four cycles.");

   div_eight_a : assert property (@(posedge core_clk) disable iff (!rst_sync_n_ff)
      (accept && opcode == 8'h84) |=> !instr_done [*7] ##1 instr_done)
      else $error("Divide did not finish in eight cycles.");

   ext_move_a : assert property (@(posedge core_clk) disable iff (!rst_sync_n_ff)
      (accept && (opcode == 8'he0 || opcode == 8'hf2)) |=> !instr_done [*2] ##1 instr_done)
      else $error("External move did not take three cycles.");

   code_move_a : assert property (@(posedge core_clk) disable iff (!rst_sync_n_ff)
      (accept && opcode == 8'h93) |-> ##1 decode_out.length == 2'h1 ##2 instr_done)
      else $error("Code move timing wrong.");

   rotate_one_a : assert property (@(posedge core_clk) disable iff (!rst_sync_n_ff)
      (accept && opcode == 8'h23) |-> ##1 (instr_done && !busy))
      else $error("Rotate did not finish in one cycle.");

   branch_taken_a : assert property (@(posedge core_clk) disable iff (!rst_sync_n_ff)
      (accept && opcode == 8'h60 && branch_taken) |=> !instr_done [*2] ##1 instr_done)
      else $error("Taken short branch not three cycles.");

   branch_skip_a : assert property (@(posedge core_clk) disable iff (!rst_sync_n_ff)
      (accept && opcode == 8'h60 && !branch_taken) |-> ##2 instr_done)
      else $error("Untaken short branch not two cycles.");

   dir_move_a : assert property (@(posedge core_clk) disable iff (!rst_sync_n_ff)
      (accept && opcode == 8'h85) |-> ##1 (busy && decode_out.length == 2'h3) ##2 instr_done)
      else $error("Direct move not three cycles.");

   flash_tag_a : assert property (@(posedge core_clk) disable iff (!rst_sync_n_ff)
      (accept && opcode == 8'hf0) |=> decode_out.flash_target == $past(flash_write_en))
      else $error("Flash target not captured.");

   nibble_a : assert property (@(posedge core_clk) disable iff (!rst_sync_n_ff)
      (accept && opcode == 8'hd6) |-> ##1 decode_out.op_class == instr_decode_pkg::OP_NIBBLE_XCH ##1 instr_done)
      else $error("Nibble exchange timing wrong.");

   busy_done_a : assert property (@(posedge core_clk) disable iff (!rst_sync_n_ff)
      !(busy && instr_done))
      else $error("Busy and done seen together.");

   // The execute stage reads the decode for the whole instruction, so it must not move while busy.
   hold_decode_a : assert property (@(posedge core_clk) disable iff (!rst_sync_n_ff)
      busy |=> $stable(decode_out))
      else $error("Decode changed while busy.");

   ptr_load_a : assert property (@(posedge core_clk) disable iff (!rst_sync_n_ff)
      (accept && opcode == 8'h90) |-> ##3 instr_done)
      else $error("Pointer load not three cycles.");

   stack_two_a : assert property (@(posedge core_clk) disable iff (!rst_sync_n_ff)
      (accept && (opcode == 8'hc0 || opcode == 8'hd0)) |-> ##1 busy ##1 instr_done)
      else $error("Push or pop not two cycles.");

   cpl_two_a : assert property (@(posedge core_clk) disable iff (!rst_sync_n_ff)
      (accept && opcode == 8'hf4) |-> ##1 busy ##1 instr_done)
      else $error("Complement not two cycles.");

   indir_move_a : assert property (@(posedge core_clk) disable iff (!rst_sync_n_ff)
      (accept && opcode == 8'hf6) |-> ##1 decode_out.indirect ##1 instr_done)
      else $error("Indirect move not two cycles.");

endmodule

// ---- verif/code_store.sv ----
`timescale 1ns/1ps
module code_store
(
   // Clock
   input  wire logic       core_clk,
   // Loading side
   input  wire logic       store_en,
   input  wire logic [3:0] store_addr,
   input  wire logic [7:0] store_byte,
   // Fetch side
   input  wire logic       fetch_en,
   input  wire logic [3:0] fetch_addr,
   output logic      [7:0] opcode
);
   logic [7:0] mem_ff [16];
   logic [7:0] last_ff = 8'h00;

   always_ff @(posedge core_clk)
   begin
      if (store_en)
         mem_ff[store_addr] <= store_byte;
   end

   always_ff @(posedge core_clk)
   begin
      if (fetch_en)
         last_ff <= mem_ff[fetch_addr];
   end

   // Outside a fetch the bus shows the inverse of the last byte, so a late sample never sees the byte just fetched.
   assign opcode = fetch_en ? mem_ff[fetch_addr] : ~last_ff;
endmodule

// ---- verif/cycle_timed_instr_decoder_tb.sv ----
`timescale 1ns/1ps
module cycle_timed_instr_decoder_tb;
   logic                      core_clk;
   logic                      rst_n;
   logic                      opcode_valid;
   logic [7:0]                opcode;
   logic                      flash_write_en;
   logic                      branch_taken;
   logic                      busy;
   logic                      instr_done;
   instr_decode_pkg::decode_s decode_out;
   logic                      store_en;
   logic [3:0]                store_addr;
   logic [7:0]                store_byte;
   logic [3:0]                slot;
   int                        err_count;
   int                        tests_run;

   always #50 core_clk = ~core_clk;

   cycle_timed_instr_decoder DUT
   (
      .core_clk       (core_clk),
      .rst_n          (rst_n),
      .opcode_valid   (opcode_valid),
      .opcode         (opcode),
      .flash_write_en (flash_write_en),
      .branch_taken   (branch_taken),
      .busy           (busy),
      .instr_done     (instr_done),
      .decode_out     (decode_out)
   );

   code_store PM
   (
      .core_clk   (core_clk),
      .store_en   (store_en),
      .store_addr (store_addr),
      .store_byte (store_byte),
      .fetch_en   (opcode_valid),
      .fetch_addr (slot),
      .opcode     (opcode)
   );

   task automatic compare(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      if (err_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Loads a byte one edge ahead so the store write never races the take edge.
   task automatic offer(input logic [7:0] opc, input logic taken, input logic flash);
      @(posedge core_clk);
      store_en   <= 1'b1;
      store_addr <= slot;
      store_byte <= opc;
      @(posedge core_clk);
      store_en       <= 1'b0;
      opcode_valid   <= 1'b1;
      branch_taken   <= taken;
      flash_write_en <= flash;
      @(posedge core_clk);
      opcode_valid <= 1'b0;
      slot         <= slot + 4'h1;
   endtask

   // Entry is opcode, byte count nibble, untaken cycle count nibble.
   task automatic run_op(input logic [15:0] e, input logic taken, input logic flash);
      int n;
      offer(e[15:8], taken, flash);
      for (n = 1; n < 12; n++)
      begin
         @(negedge core_clk);
         if (n == 1)
         begin
            compare(16'(decode_out.length), 16'(e[7:4]));
            compare(16'(decode_out.cycles), 16'(e[3:0]));
         end
         if (instr_done === 1'b1)
            break;
         compare(16'(busy), 16'h0001);
      end
      compare(16'(n), 16'(e[3:0]) + 16'(taken));
   endtask

   task automatic scen_arith();
      logic [15:0] t [] = '{16'h2811, 16'h2522, 16'h2612, 16'h2422, 16'h3811, 16'h3522, 16'h3612, 16'h3422,
                            16'h9811, 16'h9522, 16'h9612, 16'h9422};
      foreach (t[i]) run_op(t[i], 1'b0, 1'b0);
      compare(16'(decode_out.op_class), 16'(instr_decode_pkg::OP_ARITH));
   endtask

   task automatic scen_logic();
      logic [15:0] t [] = '{16'h5811, 16'h5522, 16'h5612, 16'h5422, 16'h5222, 16'h5333, 16'h4811, 16'h4522,
                            16'h4612, 16'h4422, 16'h4222, 16'h4333, 16'h6811, 16'h6522, 16'h6612, 16'h6422,
                            16'h6222, 16'h6333};
      foreach (t[i]) run_op(t[i], 1'b0, 1'b0);
   endtask

   task automatic scen_unary();
      logic [15:0] t [] = '{16'he411, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hc411, 16'hf412, 16'hd411};
      foreach (t[i]) run_op(t[i], 1'b0, 1'b0);
   endtask

   task automatic scen_moves();
      logic [15:0] t [] = '{16'h8533, 16'h7533, 16'hf612, 16'ha622, 16'h7622, 16'h9033, 16'hc022, 16'hd022,
                            16'hc811, 16'hc522, 16'hc612};
      foreach (t[i]) run_op(t[i], 1'b0, 1'b0);
      compare(16'({decode_out.op_class, decode_out.indirect}), 16'({instr_decode_pkg::OP_EXCHANGE, 1'b1}));
   endtask

   task automatic scen_incdec();
      logic [15:0] t [] = '{16'h0411, 16'h0811, 16'h0522, 16'h0612, 16'h1411, 16'h1811, 16'h1522, 16'h1612,
                            16'ha311, 16'ha414, 16'h8418};
      foreach (t[i]) run_op(t[i], 1'b0, 1'b0);
      compare(16'(decode_out.op_class), 16'(instr_decode_pkg::OP_MULDIV));
   endtask

   task automatic scen_memory();
      logic [15:0] t [] = '{16'h9313, 16'h8313, 16'he213, 16'hf213, 16'he013, 16'hf013};
      foreach (t[i]) run_op(t[i], 1'b0, 1'b0);
      run_op(16'hd612, 1'b0, 1'b0);
      compare(16'(decode_out.op_class), 16'(instr_decode_pkg::OP_NIBBLE_XCH));
      compare(16'(decode_out.indirect), 16'h0001);
   endtask

   // A flash target is only meaningful for the two external writes, never for a read.
   task automatic scen_flash();
      run_op(16'hf013, 1'b0, 1'b1);
      compare(16'({decode_out.flash_target, decode_out.ext_addr16}), 16'h0003);
      run_op(16'hf213, 1'b0, 1'b1);
      compare(16'({decode_out.flash_target, decode_out.ext_addr16}), 16'h0002);
      run_op(16'he013, 1'b0, 1'b1);
      compare(16'(decode_out.flash_target), 16'h0000);
      run_op(16'hf013, 1'b0, 1'b0);
      compare(16'(decode_out.flash_target), 16'h0000);
   endtask

   task automatic scen_branch();
      run_op(16'h6022, 1'b0, 1'b0);
      compare(16'(decode_out.is_cond_branch), 16'h0001);
      run_op(16'h6022, 1'b1, 1'b0);
      run_op(16'hb534, 1'b0, 1'b0);
      run_op(16'hb534, 1'b1, 1'b0);
   endtask

   // Valid stays high through the multiply, so the divide offered meanwhile must wait for the done cycle.
   task automatic scen_back_to_back();
      int n;
      int first;
      int second;
      first  = 0;
      second = 0;
      @(posedge core_clk);
      store_en   <= 1'b1;
      store_addr <= slot;
      store_byte <= 8'ha4;
      @(posedge core_clk);
      store_addr <= slot + 4'h1;
      store_byte <= 8'h84;
      @(posedge core_clk);
      store_en       <= 1'b0;
      opcode_valid   <= 1'b1;
      branch_taken   <= 1'b0;
      flash_write_en <= 1'b0;
      @(posedge core_clk);
      slot <= slot + 4'h1;
      for (n = 1; n < 20; n++)
      begin
         @(negedge core_clk);
         if (n == 2)
            compare(16'(decode_out.cycles), 16'(instr_decode_pkg::CYC_MUL));
         if (instr_done === 1'b1 && first == 0)
            first = n;
         else if (instr_done === 1'b1)
            second = n;
      end
      compare(16'(first), 16'h0004);
      compare(16'(second), 16'(instr_decode_pkg::CYC_MUL) + 16'(instr_decode_pkg::CYC_DIV));
      @(posedge core_clk);
      opcode_valid <= 1'b0;
   endtask

   initial
   begin
      #(5000 * 100);
      err_count++;
      complete_run();
   end

   initial
   begin
      core_clk       = 1'b0;
      rst_n          = 1'b0;
      opcode_valid   = 1'b0;
      flash_write_en = 1'b0;
      branch_taken   = 1'b0;
      store_en       = 1'b0;
      store_addr     = 4'h0;
      store_byte     = 8'h00;
      slot           = 4'h0;
      err_count      = 0;
      tests_run      = 0;
      repeat (4) @(posedge core_clk);
      #1;
      compare({busy, instr_done, decode_out}, 16'h0000);
      @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      scen_arith();
      scen_logic();
      scen_unary();
      scen_moves();
      scen_incdec();
      scen_memory();
      scen_flash();
      scen_branch();
      scen_back_to_back();
      complete_run();
   end
endmodule
